// ==== bscan_cells.sv ====
// boundary-scan cell chain: three cells per pin, shift and update stages
`default_nettype none
module bscan_cells
    import bscan_pkg::*;
#(
    parameter int unsigned LEN = BSR_SMALL
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     capture_i,
    input  wire logic                     shift_i,
    input  wire logic                     update_i,
    input  wire logic                     tdi_i,
    input  wire logic [LEN/CELLS_PIN-1:0] pin_in_i,
    input  wire logic [LEN/CELLS_PIN-1:0] core_out_i,
    input  wire logic [LEN/CELLS_PIN-1:0] core_oe_i,
    output logic                          so_o,
    output logic [LEN/CELLS_PIN-1:0]      upd_out_o,
    output logic [LEN/CELLS_PIN-1:0]      upd_oe_o
);
    localparam int unsigned NPINS = LEN / CELLS_PIN;

    logic [LEN-1:0] chain_q;
    logic [LEN-1:0] cap_d;
    logic [LEN-1:0] upd_q;

    // cell order per pin: input, output, enable
    for (genvar p = 0; p < NPINS; p++) begin : g_pin
        assign cap_d[CELLS_PIN*p]     = pin_in_i[p];
        assign cap_d[CELLS_PIN*p + 1] = core_out_i[p];
        assign cap_d[CELLS_PIN*p + 2] = core_oe_i[p];
        assign upd_out_o[p]           = upd_q[CELLS_PIN*p + 1];
        assign upd_oe_o[p]            = upd_q[CELLS_PIN*p + 2];
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chain_q <= '0;
        end else if (capture_i) begin
            chain_q <= cap_d;
        end else if (shift_i) begin
            chain_q <= {tdi_i, chain_q[LEN-1:1]};
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            upd_q <= '0;
        end else if (update_i) begin
            upd_q <= chain_q;
        end
    end

    assign so_o = chain_q[0];
endmodule : bscan_cells
`default_nettype wire

// ==== bscan_jtag_host.sv ====
// test controller model: drives the serial test port, collects the serial output
`default_nettype none
module bscan_jtag_host
    import bscan_pkg::*;
(
    input  wire logic     clk_sys_i,
    input  wire logic     tdo_i,
    output var  jtag_in_t jtag_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // test clock stands low between frames
    initial jtag_o = '0;

    ////////////////////////////////////////////////////////////////////////////////////////
    // one test clock of 8 system clocks, output taken at the rising edge
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        jtag_o.tms = tms;
        jtag_o.tdi = tdi;
        repeat (4) @(negedge clk_sys_i);
        tdo = tdo_i;
        jtag_o.tck = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        jtag_o.tck = 1'b0;
    endtask : tick

    // five clocks with mode select high, then idle
    task automatic reset_tap;
        logic t;
        for (int i = 0; i < 5; i++) begin
            tick(1'b1, 1'b0, t);
        end
        tick(1'b0, 1'b0, t);
    endtask : reset_tap

    // from idle: scan n bits lsb first through instruction or data path, back to idle
    task automatic shift(input logic ir, input int n, input logic [2047:0] din,
                         output logic [2047:0] dout);
        logic t;
        dout = '0;
        tick(1'b1, 1'b0, t);
        if (ir) begin
            tick(1'b1, 1'b0, t);
        end
        tick(1'b0, 1'b0, t);
        tick(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], dout[i]);
        end
        tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
    endtask : shift
endmodule : bscan_jtag_host
`default_nettype wire

// ==== bscan_pkg.sv ====
// constants, opcodes and carrier types of the boundary-scan test port
`default_nettype none
package bscan_pkg;
    localparam int unsigned IR_LEN      = 10;
    localparam logic [9:0]  IR_CAPTURE  = 10'h001;
    localparam logic [9:0]  OP_EXTEST   = 10'h000;
    localparam logic [9:0]  OP_RECONFIG = 10'h001;
    localparam logic [9:0]  OP_SAMPLE   = 10'h005;
    localparam logic [9:0]  OP_IDCODE   = 10'h006;
    localparam logic [9:0]  OP_USERCODE = 10'h007;
    localparam logic [9:0]  OP_CLAMP    = 10'h00a;
    localparam logic [9:0]  OP_HIGHZ    = 10'h00b;
    localparam logic [9:0]  OP_TRACE    = 10'h00e;
    localparam logic [9:0]  OP_BYPASS   = 10'h3ff;
    localparam int unsigned ID_LEN      = 32;
    // identity values are arbitrary
    localparam logic [3:0]  ID_VERSION  = 4'h1;
    localparam logic [15:0] ID_PART     = 16'h1234;
    localparam logic [10:0] ID_MAKER    = 11'h055;
    localparam logic [31:0] ID_WORD     = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    localparam int unsigned BSR_SMALL   = 1029;
    localparam int unsigned BSR_MEDIUM  = 1665;
    localparam int unsigned BSR_LARGE   = 1941;
    localparam int unsigned CELLS_PIN   = 3;
    localparam int unsigned TRACE_W     = 8;
    localparam int unsigned TRACE_DEPTH = 16;
    localparam int unsigned TRACE_BITS  = TRACE_W * TRACE_DEPTH;
    localparam int unsigned CFG_RATE_MHZ = 100;
    localparam int unsigned CFG_TIME_MS  = 100;
    localparam int unsigned CFG_MAX_BYTES = CFG_RATE_MHZ * CFG_TIME_MS * 1000;
    localparam int unsigned CFG_CNT_W    = 24;

    typedef enum logic [15:0] {
        S_TLR  = 16'h0001, S_RTI  = 16'h0002, S_SDRS = 16'h0004, S_CDR  = 16'h0008,
        S_SDR  = 16'h0010, S_E1DR = 16'h0020, S_PDR  = 16'h0040, S_E2DR = 16'h0080,
        S_UDR  = 16'h0100, S_SIRS = 16'h0200, S_CIR  = 16'h0400, S_SIR  = 16'h0800,
        S_E1IR = 16'h1000, S_PIR  = 16'h2000, S_E2IR = 16'h4000, S_UIR  = 16'h8000
    } tap_state_t;

    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_ID, SEL_USER, SEL_BSR, SEL_TRACE
    } dr_sel_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtag_in_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } cfg_byte_t;

    function automatic int unsigned bsr_len(input int unsigned size_sel);
        return (size_sel == 0) ? BSR_SMALL : (size_sel == 1) ? BSR_MEDIUM : BSR_LARGE;
    endfunction : bsr_len
endpackage : bscan_pkg
`default_nettype wire

// ==== bscan_tap.sv ====
// boundary-scan test access port with id, user code, trace and reconfiguration
`default_nettype none
module bscan_tap
    import bscan_pkg::*;
#(
    parameter int unsigned SIZE_SEL  = 0,
    parameter int unsigned CFG_BYTES = CFG_MAX_BYTES
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  sys_rst_i,
    input  wire jtag_in_t              jtag_i,
    output logic                       tdo_o,
    output logic                       tdo_oe_o,
    input  wire logic [31:0]           usercode_i,
    input  wire logic                  reconfig_request_pin_n_i,
    input  wire cfg_byte_t             cfg_i,
    input  wire logic [TRACE_W-1:0]    probe_i,
    input  wire logic [bsr_len(SIZE_SEL)/CELLS_PIN-1:0] pin_in_i,
    input  wire logic [bsr_len(SIZE_SEL)/CELLS_PIN-1:0] core_out_i,
    input  wire logic [bsr_len(SIZE_SEL)/CELLS_PIN-1:0] core_oe_i,
    input  wire logic [bsr_len(SIZE_SEL)/CELLS_PIN-1:0] keeper_en_i,
    output logic [bsr_len(SIZE_SEL)/CELLS_PIN-1:0]      pin_out_o,
    output logic [bsr_len(SIZE_SEL)/CELLS_PIN-1:0]      pin_oe_o,
    output logic [bsr_len(SIZE_SEL)/CELLS_PIN-1:0]      pin_keep_o,
    output logic                       reconfig_o,
    output logic                       config_done_o,
    output logic [7:0]                 config_sum_o
);
    localparam int unsigned BSR_LEN = bsr_len(SIZE_SEL);
    localparam int unsigned NPINS   = BSR_LEN / CELLS_PIN;
    function automatic dr_sel_t dr_select(input logic [9:0] op);
        if (op == OP_IDCODE) begin
            return SEL_ID;
        end else if (op == OP_USERCODE) begin
            return SEL_USER;
        end else if (op == OP_EXTEST || op == OP_SAMPLE) begin
            return SEL_BSR;
        end else if (op == OP_TRACE) begin
            return SEL_TRACE;
        end else begin
            return SEL_BYPASS;
        end
    endfunction : dr_select
    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and test clock edges
    jtag_in_t   sync1_q, sync2_q;
    logic       tck_prev_q, req_s1_q, req_s2_q, req_prev_q, tck_rise, tck_fall;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            tck_prev_q <= 1'b0;
            req_s1_q   <= 1'b1;
            req_s2_q   <= 1'b1;
            req_prev_q <= 1'b1;
        end else begin
            sync1_q    <= jtag_i;
            sync2_q    <= sync1_q;
            tck_prev_q <= sync2_q.tck;
            req_s1_q   <= reconfig_request_pin_n_i;
            req_s2_q   <= req_s1_q;
            req_prev_q <= req_s2_q;
        end
    end
    assign tck_rise = sync2_q.tck & ~tck_prev_q;
    assign tck_fall = ~sync2_q.tck & tck_prev_q;
    ////////////////////////////////////////////////////////////////////////////
    tap_state_t tap_q, tap_d;
    always_comb begin
        case (tap_q)
            S_TLR:   tap_d = sync2_q.tms ? S_TLR  : S_RTI;
            S_RTI:   tap_d = sync2_q.tms ? S_SDRS : S_RTI;
            S_SDRS:  tap_d = sync2_q.tms ? S_SIRS : S_CDR;
            S_CDR:   tap_d = sync2_q.tms ? S_E1DR : S_SDR;
            S_SDR:   tap_d = sync2_q.tms ? S_E1DR : S_SDR;
            S_E1DR:  tap_d = sync2_q.tms ? S_UDR  : S_PDR;
            S_PDR:   tap_d = sync2_q.tms ? S_E2DR : S_PDR;
            S_E2DR:  tap_d = sync2_q.tms ? S_UDR  : S_SDR;
            S_UDR:   tap_d = sync2_q.tms ? S_SDRS : S_RTI;
            S_SIRS:  tap_d = sync2_q.tms ? S_TLR  : S_CIR;
            S_CIR:   tap_d = sync2_q.tms ? S_E1IR : S_SIR;
            S_SIR:   tap_d = sync2_q.tms ? S_E1IR : S_SIR;
            S_E1IR:  tap_d = sync2_q.tms ? S_UIR  : S_PIR;
            S_PIR:   tap_d = sync2_q.tms ? S_E2IR : S_PIR;
            S_E2IR:  tap_d = sync2_q.tms ? S_UIR  : S_SIR;
            S_UIR:   tap_d = sync2_q.tms ? S_SDRS : S_RTI;
            default: tap_d = S_TLR;
        endcase
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tap_q <= S_TLR;
        end else if (tck_rise) begin
            tap_q <= tap_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    logic [IR_LEN-1:0] ir_sh_q, ir_q;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ir_sh_q <= IR_CAPTURE;
            ir_q    <= OP_IDCODE;
        end else if (tap_q == S_TLR) begin
            ir_q <= OP_IDCODE;
        end else if (tck_rise) begin
            if (tap_q == S_CIR) begin
                ir_sh_q <= IR_CAPTURE;
            end else if (tap_q == S_SIR) begin
                ir_sh_q <= {sync2_q.tdi, ir_sh_q[IR_LEN-1:1]};
            end else if (tap_q == S_UIR) begin
                ir_q <= ir_sh_q;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    logic [ID_LEN-1:0]     dr_sh_q;
    logic [TRACE_BITS-1:0] trace_sh_q;
    logic [TRACE_W-1:0]    trace_mem [TRACE_DEPTH];
    logic [4:0]            trace_ptr_q;
    logic [NPINS-1:0]      upd_out, upd_oe, oe_d;
    dr_sel_t               sel;
    logic                  cap_dr, sh_dr, arm_trace, reconf_evt, bsr_so;
    assign sel       = dr_select(ir_q);
    assign cap_dr    = tck_rise && (tap_q == S_CDR);
    assign sh_dr     = tck_rise && (tap_q == S_SDR);
    assign arm_trace = tck_rise && (tap_q == S_UIR) && (ir_sh_q == OP_TRACE);
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dr_sh_q <= '0;
        end else if (cap_dr) begin
            case (sel)
                SEL_ID:   dr_sh_q <= ID_WORD;
                SEL_USER: dr_sh_q <= usercode_i;
                default:  dr_sh_q <= '0;
            endcase
        end else if (sh_dr) begin
            if (sel == SEL_BYPASS) begin
                dr_sh_q[0] <= sync2_q.tdi;
            end else begin
                dr_sh_q <= {sync2_q.tdi, dr_sh_q[ID_LEN-1:1]};
            end
        end
    end
    // analyzer: record probe words after arming, read them back as one scan
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trace_ptr_q <= 5'h10;
        end else if (arm_trace) begin
            trace_ptr_q <= 5'h00;
        end else if (!trace_ptr_q[4]) begin
            trace_ptr_q <= trace_ptr_q + 5'h01;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!trace_ptr_q[4]) begin
            trace_mem[trace_ptr_q[3:0]] <= probe_i;
        end
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trace_sh_q <= '0;
        end else if (cap_dr && sel == SEL_TRACE) begin
            for (int i = 0; i < TRACE_DEPTH; i++) begin
                trace_sh_q[i*TRACE_W +: TRACE_W] <= trace_mem[i];
            end
        end else if (sh_dr && sel == SEL_TRACE) begin
            trace_sh_q <= {sync2_q.tdi, trace_sh_q[TRACE_BITS-1:1]};
        end
    end
    bscan_cells #(.LEN(BSR_LEN)) u_cells (
        .clk_sys_i  (clk_sys_i),
        .sys_rst_i  (sys_rst_i),
        .capture_i  (cap_dr && sel == SEL_BSR),
        .shift_i    (sh_dr && sel == SEL_BSR),
        .update_i   (tck_rise && tap_q == S_UDR && sel == SEL_BSR),
        .tdi_i      (sync2_q.tdi),
        .pin_in_i   (pin_in_i),
        .core_out_i (core_out_i),
        .core_oe_i  (core_oe_i),
        .so_o       (bsr_so),
        .upd_out_o  (upd_out),
        .upd_oe_o   (upd_oe)
    );
    ////////////////////////////////////////////////////////////////////////////
    // serial output on falling test clock
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_o <= (tap_q == S_SIR) || (tap_q == S_SDR);
            if (tap_q == S_SIR) begin
                tdo_o <= ir_sh_q[0];
            end else begin
                case (dr_select(ir_q))
                    SEL_BSR:   tdo_o <= bsr_so;
                    SEL_TRACE: tdo_o <= trace_sh_q[0];
                    default:   tdo_o <= dr_sh_q[0];
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        if (ir_q == OP_HIGHZ) begin
            oe_d = '0;
        end else if (ir_q == OP_CLAMP || ir_q == OP_EXTEST) begin
            oe_d = upd_oe;
        end else begin
            oe_d = core_oe_i;
        end
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_out_o  <= '0;
            pin_oe_o   <= '0;
            pin_keep_o <= '0;
        end else begin
            pin_out_o  <= (ir_q == OP_CLAMP || ir_q == OP_EXTEST) ? upd_out : core_out_i;
            pin_oe_o   <= oe_d;
            pin_keep_o <= keeper_en_i & ~oe_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // configuration and reconfiguration
    logic [CFG_CNT_W-1:0] cfg_cnt_q;
    assign reconf_evt = (tck_rise && tap_q == S_UIR && ir_sh_q == OP_RECONFIG)
                        || (req_prev_q && !req_s2_q);
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reconfig_o    <= 1'b0;
            config_done_o <= 1'b0;
            config_sum_o  <= 8'h00;
            cfg_cnt_q     <= '0;
        end else begin
            reconfig_o <= reconf_evt;
            if (reconf_evt) begin
                config_done_o <= 1'b0;
                config_sum_o  <= 8'h00;
                cfg_cnt_q     <= '0;
            end else if (cfg_i.valid && !config_done_o) begin
                config_sum_o <= config_sum_o + cfg_i.data;
                cfg_cnt_q    <= cfg_cnt_q + CFG_CNT_W'(1);
                if (cfg_cnt_q == CFG_CNT_W'(CFG_BYTES - 1)) begin
                    config_done_o <= 1'b1;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    AST_IR_UPDATE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (tck_rise && tap_q == S_UIR) |=> ir_q == $past(ir_sh_q))
        else $error("instruction not loaded from shift stage");
    AST_ID_WORD: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cap_dr && sel == SEL_ID) |=> dr_sh_q == {ID_VERSION, ID_PART, ID_MAKER, 1'b1})
        else $error("id word wrong at capture");
    AST_ID_LSB: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cap_dr && sel == SEL_ID) ##1 (!tck_fall)[*3] ##1 tck_fall |=> tdo_o)
        else $error("first id bit out is not one");
    AST_USERCODE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cap_dr && sel == SEL_USER) |=> dr_sh_q == $past(usercode_i))
        else $error("user code not captured");
    AST_BYPASS: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cap_dr && ir_q == 10'h2aa) |=> dr_sh_q[0] == 1'b0)
        else $error("unassigned opcode did not select bypass");
    AST_HIGHZ: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (ir_q == OP_HIGHZ) |=> pin_oe_o == '0)
        else $error("pins driven under high impedance");
    AST_CLAMP: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (ir_q == OP_CLAMP) |=> pin_out_o == $past(upd_out) && pin_oe_o == $past(upd_oe))
        else $error("clamp does not follow update stage");
    AST_KEEP: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (ir_q == OP_HIGHZ) |=> pin_keep_o == $past(keeper_en_i))
        else $error("keeper lost while pins float");
    AST_RECONF: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (tck_rise && tap_q == S_UIR && ir_sh_q == OP_RECONFIG) |=> reconfig_o ##1 !config_done_o)
        else $error("reconfiguration instruction had no effect");
    AST_TDO_EDGE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $changed(tdo_o) |-> $past(tck_fall))
        else $error("data out changed off the falling edge");
endmodule : bscan_tap
`default_nettype wire

// ==== bscan_tap_tb.sv ====
// self-checking bench of the boundary-scan test port
`default_nettype none
module bscan_tap_tb
    import bscan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned NP = BSR_SMALL / CELLS_PIN;
    localparam int unsigned NB = 8;

    logic          clk_sys_i = 1'b0;
    logic          sys_rst_i = 1'b1;
    jtag_in_t      jtag;
    logic          tdo, tdo_oe, reconfig, done;
    logic          tdo_line;
    logic [31:0]   usercode = 32'hc0de_5a17;
    logic          rcfg_pin_n = 1'b1;
    cfg_byte_t     cfg = '0;
    logic [7:0]    probe = 8'h00;
    logic [7:0]    sum;
    logic [NP-1:0] pin_in = NP'({172{2'b10}});
    logic [NP-1:0] core_out = NP'({115{3'b110}});
    logic [NP-1:0] core_oe = '1;
    logic [NP-1:0] keeper_en = NP'({172{2'b01}});
    logic [NP-1:0] pin_out, pin_oe, pin_keep;
    int            err_count = 0;
    int            total_checks = 0;
    int            pulse_count = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (reconfig === 1'b1) pulse_count <= pulse_count + 1;

    bscan_tap #(.SIZE_SEL(0), .CFG_BYTES(NB)) dut_u (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .jtag_i(jtag), .tdo_o(tdo),
        .tdo_oe_o(tdo_oe), .usercode_i(usercode), .reconfig_request_pin_n_i(rcfg_pin_n),
        .cfg_i(cfg), .probe_i(probe), .pin_in_i(pin_in), .core_out_i(core_out),
        .core_oe_i(core_oe), .keeper_en_i(keeper_en), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe), .pin_keep_o(pin_keep), .reconfig_o(reconfig),
        .config_done_o(done), .config_sum_o(sum));

    // released data line reads inverted, so a dropped enable corrupts the scan
    assign tdo_line = tdo_oe ? tdo : ~tdo;
    bscan_jtag_host host_u (.clk_sys_i(clk_sys_i), .tdo_i(tdo_line), .jtag_o(jtag));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [2047:0] exp, input logic [2047:0] got);
        total_checks++;
        if (exp !== got) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // back-to-back bytes from a falling edge, sum returned
    task automatic feed(input int n, inout logic [7:0] s);
        for (int i = 0; i < n; i++) begin
            cfg.valid = 1'b1;
            cfg.data = 8'h31 + 8'(i * 7);
            s = s + cfg.data;
            @(negedge clk_sys_i);
        end
        cfg.valid = 1'b0;
        @(negedge clk_sys_i);
    endtask : feed

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_idcode;
        logic [2047:0] q;
        host_u.reset_tap();
        host_u.shift(1'b0, 32, '0, q);
        chk("idcode", 2048'(ID_WORD), 2048'(q[31:0]));
        chk("id_first_bit", 2048'(1'b1), 2048'(q[0]));
        chk("tdo_oe_idle", 2048'(1'b0), 2048'(tdo_oe));
    endtask : t_idcode

    task automatic t_user;
        logic [2047:0] q;
        host_u.shift(1'b1, 20, 2048'({OP_USERCODE, 10'h155}), q);
        chk("ir_capture", 2048'(IR_CAPTURE), 2048'(q[9:0]));
        chk("ir_length", 2048'(10'h155), 2048'(q[19:10]));
        host_u.shift(1'b0, 32, '0, q);
        chk("usercode", 2048'(usercode), 2048'(q[31:0]));
    endtask : t_user

    // sample pins, check chain length, preload and clamp
    task automatic t_bsr;
        logic [2047:0] d, q;
        logic [NP-1:0] g, eo, eoe;
        d = '0;
        d[7:0] = 8'he1;
        for (int p = 0; p < NP; p++) begin
            d[8 + 3 * p + 1] = p[0];
            d[8 + 3 * p + 2] = ~p[0];
            eo[p] = p[0];
            eoe[p] = ~p[0];
        end
        host_u.shift(1'b1, 10, 2048'(OP_SAMPLE), q);
        host_u.shift(1'b0, BSR_SMALL + 8, d, q);
        for (int p = 0; p < NP; p++) g[p] = q[3 * p];
        chk("bsr_capture", 2048'(pin_in), 2048'(g));
        chk("bsr_length", 2048'(8'he1), 2048'(q[BSR_SMALL +: 8]));
        host_u.shift(1'b1, 10, 2048'(OP_CLAMP), q);
        chk("clamp_pins", 2048'({eoe, eo}), 2048'({pin_oe, pin_out}));
        host_u.shift(1'b1, 10, 2048'(OP_EXTEST), q);
        chk("extest_pins", 2048'({eoe, eo}), 2048'({pin_oe, pin_out}));
        chk("extest_keep", 2048'(keeper_en & ~eoe), 2048'(pin_keep));
    endtask : t_bsr

    task automatic t_bypass;
        logic [2047:0] q;
        logic [9:0]    ops [4] = '{OP_BYPASS, OP_HIGHZ, OP_CLAMP, 10'h2aa};
        for (int i = 0; i < 4; i++) begin
            host_u.shift(1'b1, 10, 2048'(ops[i]), q);
            host_u.shift(1'b0, 8, 2048'(8'hb4), q);
            chk("bypass_bit", 2048'(8'h68), 2048'(q[7:0]));
            if (i == 1) begin
                chk("highz_oe", '0, 2048'(pin_oe));
                chk("keeper", 2048'(keeper_en), 2048'(pin_keep));
            end else if (i != 2) begin
                chk("core_pins", 2048'({core_oe, core_out}), 2048'({pin_oe, pin_out}));
            end
        end
    endtask : t_bypass

    task automatic t_trace;
        logic [2047:0] q;
        probe = 8'hc3;
        host_u.shift(1'b1, 10, 2048'(OP_TRACE), q);
        host_u.shift(1'b0, TRACE_BITS, '0, q);
        chk("trace", 2048'({TRACE_DEPTH{8'hc3}}), 2048'(q[TRACE_BITS-1:0]));
    endtask : t_trace

    task automatic t_config;
        logic [2047:0] q;
        logic [7:0]    s;
        int            pc;
        s = 8'h00;
        feed(NB - 1, s);
        chk("done_early", 2048'(1'b0), 2048'(done));
        feed(1, s);
        chk("done", 2048'(1'b1), 2048'(done));
        feed(2, q[7:0]);
        chk("sum", 2048'(s), 2048'(sum));
        pc = pulse_count;
        host_u.shift(1'b1, 10, 2048'(OP_RECONFIG), q);
        chk("reconfig_ir", 2048'(pc + 1), 2048'(pulse_count));
        chk("cleared", 2048'(9'h000), 2048'({done, sum}));
        s = 8'h00;
        feed(NB, s);
        chk("reload", 2048'({1'b1, s}), 2048'({done, sum}));
        rcfg_pin_n = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        rcfg_pin_n = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        chk("reconfig_pin", 2048'(pc + 2), 2048'(pulse_count));
        chk("pin_cleared", 2048'(1'b0), 2048'(done));
    endtask : t_config

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        t_idcode();
        t_user();
        t_bsr();
        t_bypass();
        t_trace();
        t_config();
        print_verdict();
    end
endmodule : bscan_tap_tb
`default_nettype wire
